// ===== sim/fopg_clock_ctrl_properties.sv
// concurrent checks for the clock control block
`timescale 1ns/10ps
`default_nettype none
`include "fopg_defines.vh"
module fopg_chk #(parameter NPER = 8) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [19:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_bit_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sub_tick_i,
    input wire logic [NPER-1:0] periph_wr_req_i,
    input wire logic fast_osc_run_o,
    input wire logic cpu_clk_en_o,
    input wire logic [NPER-1:0] periph_clk_en_o,
    input wire logic [NPER-1:0] periph_wr_o,
    input wire logic [NPER-1:0] periph_resetn_o,
    input wire logic aux_clk_en_o,
    input wire logic aux_wr_o,
    input wire logic aux_resetn_o,
    input wire logic rtc_sub_clk_en_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_run_follows_en: assert property (sfr_wr_i && !sfr_bit_i && sfr_addr_i == `FOPG_ADDR_FOC
        |=> ##1 fast_osc_run_o == $past(sfr_wdata_i[0], 2)) else $error("run level wrong");
    a_gate_follows_en: assert property (sfr_wr_i && !sfr_bit_i && sfr_addr_i == `FOPG_ADDR_PCE
        |=> ##1 periph_resetn_o == $past(sfr_wdata_i, 2)) else $error("gate reset wrong");
    a_clk_needs_cpu: assert property ((periph_clk_en_o & ~{NPER{cpu_clk_en_o}}) == '0)
        else $error("gated clock without cpu pulse");
    a_wr_gated: assert property ($stable(periph_resetn_o)
        |-> periph_wr_o == ($past(periph_wr_req_i) & periph_resetn_o)) else $error("write gate wrong");
    a_aux_tracks_adc: assert property ({aux_clk_en_o, aux_wr_o, aux_resetn_o} ==
        {periph_clk_en_o[`FOPG_PCE_ADC], periph_wr_o[`FOPG_PCE_ADC], periph_resetn_o[`FOPG_PCE_ADC]})
        else $error("aux gate wrong");
    a_rtc_sub_free: assert property ($past(resetn_i)
        |-> rtc_sub_clk_en_o == $past(sub_tick_i)) else $error("rtc subclock gated");
    a_unused_zero: assert property (sfr_rd_i && sfr_addr_i == `FOPG_ADDR_FOC
        |=> (sfr_rdata_o & 8'hF2) == 8'h00) else $error("unused bits set");
    a_flag_needs_run: assert property ((!fast_osc_run_o) [*3] ##0
        (sfr_rd_i && sfr_addr_i == `FOPG_ADDR_FOC) |=> !sfr_rdata_o[3]) else $error("flag without run");
endmodule // fopg_chk
bind fopg_clock_ctrl fopg_chk #(.NPER(NPER)) u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_bit_i(sfr_bit_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .sub_tick_i(sub_tick_i),
    .periph_wr_req_i(periph_wr_req_i), .fast_osc_run_o(fast_osc_run_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .periph_wr_o(periph_wr_o), .periph_resetn_o(periph_resetn_o),
    .aux_clk_en_o(aux_clk_en_o), .aux_wr_o(aux_wr_o), .aux_resetn_o(aux_resetn_o),
    .rtc_sub_clk_en_o(rtc_sub_clk_en_o));
`default_nettype wire

// ===== sim/fopg_clock_ctrl_tb.sv
// testbench for the clock control block
`timescale 1ns/10ps
`default_nettype none
`include "fopg_defines.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t: got %h want %h", $time, a, e); end end
module fopg_clock_ctrl_tb;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, bw = 1'b0, rd = 1'b0, sub = 1'b0, rdy = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [2:0] sel = 3'h0;
    logic [19:0] addr = 20'h00000;
    logic [7:0] wd = 8'h00, req = 8'h00, rdata, pwr, prst;
    logic run, cpu, arst, awr;
    int error_cnt = 0, checks_done = 0, n;
    always #2.5 clk = ~clk;
    always @(negedge clk) begin
        ph <= ph + 2'h1;
        sub <= (ph == 2'h3);
    end
    fopg_clock_ctrl dut (.core_clk_i(clk), .resetn_i(resetn), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_bit_i(bw), .sfr_bit_sel_i(sel), .sfr_wdata_i(wd), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .ih_tick_i(1'b1), .mx_tick_i(1'b1), .sub_tick_i(sub), .fast_osc_tick_i(1'b1),
        .fast_osc_ready_i(rdy), .periph_wr_req_i(req), .fast_osc_run_o(run), .cpu_clk_en_o(cpu),
        .periph_clk_en_o(), .periph_wr_o(pwr), .periph_resetn_o(prst), .aux_clk_en_o(),
        .aux_wr_o(awr), .aux_resetn_o(arst), .rtc_sub_clk_en_o());
    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic acc(input logic [19:0] a, input logic w, input logic b, input logic [2:0] s,
        input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr = w;
        rd = !w;
        bw = b;
        sel = s;
        wd = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic chk_rd(input logic [19:0] a, input logic [7:0] e);
        acc(a, 1'b0, 1'b0, 3'h0, 8'h00);
        `CHK(rdata, e)
    endtask
    task automatic count(input int cyc, input int e);
        repeat (40) @(negedge clk);
        n = 0;
        repeat (cyc) @(posedge clk) n += cpu;
        `CHK(n, e)
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_sim;
    end
    initial begin
        repeat (6) @(negedge clk);
        `CHK(prst, 8'h00)
        `CHK(run, 1'b0)
        resetn = 1'b1;
        chk_rd(`FOPG_ADDR_PCE, 8'h00);
        chk_rd(`FOPG_ADDR_FOC, 8'h00);
        chk_rd(`FOPG_ADDR_SCD, 8'h09);
        chk_rd(20'hF00F1, 8'h00);
        count(40, 20);
        acc(`FOPG_ADDR_SCD, 1'b1, 1'b0, 3'h0, 8'h05);
        count(64, 2);
        acc(`FOPG_ADDR_SCD, 1'b1, 1'b0, 3'h0, 8'h48);
        count(64, 8);
        acc(`FOPG_ADDR_SCD, 1'b1, 1'b0, 3'h0, 8'h09);
        acc(`FOPG_ADDR_FOC, 1'b1, 1'b0, 3'h0, 8'hFB);
        @(negedge clk);
        `CHK(run, 1'b1)
        chk_rd(`FOPG_ADDR_FOC, 8'h01);
        rdy = 1'b1;
        repeat (20000) @(negedge clk);
        acc(`FOPG_ADDR_FOC, 1'b1, 1'b1, 3'h2, 8'h04);
        repeat (20) @(negedge clk);
        chk_rd(`FOPG_ADDR_FOC, 8'h0D);
        count(40, 40);
        acc(`FOPG_ADDR_FOC, 1'b1, 1'b1, 3'h2, 8'h00);
        repeat (20) @(negedge clk);
        chk_rd(`FOPG_ADDR_FOC, 8'h01);
        count(40, 20);
        acc(`FOPG_ADDR_FOC, 1'b1, 1'b1, 3'h0, 8'h00);
        @(negedge clk);
        `CHK(run, 1'b0)
        rdy = 1'b0;
        for (int i = 0; i < 8; i++) acc(`FOPG_ADDR_PCE, 1'b1, 1'b1, i[2:0], 8'hFF);
        chk_rd(`FOPG_ADDR_PCE, 8'hFF);
        req = 8'hFF;
        repeat (3) @(negedge clk);
        `CHK(pwr, 8'hFF)
        acc(`FOPG_ADDR_PCE, 1'b1, 1'b0, 3'h0, 8'h20);
        repeat (3) @(negedge clk);
        `CHK(pwr, 8'h20)
        `CHK(arst, 1'b1)
        acc(`FOPG_ADDR_PCE, 1'b1, 1'b0, 3'h0, 8'h00);
        repeat (3) @(negedge clk);
        `CHK(prst, 8'h00)
        `CHK(awr, 1'b0)
        end_sim;
    end
endmodule // fopg_clock_ctrl_tb
`default_nettype wire

// ===== verilog/fopg_clock_ctrl.v
// fast oscillator select, cpu clock divider and peripheral gates
`timescale 1ns/10ps
`default_nettype none
`include "fopg_defines.vh"
module fopg_clock_ctrl #(
    parameter NPER = 8
) (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [19:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_bit_i,
    input wire [2:0] sfr_bit_sel_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    output reg [7:0] sfr_rdata_o,
    input wire ih_tick_i,
    input wire mx_tick_i,
    input wire sub_tick_i,
    input wire fast_osc_tick_i,
    input wire fast_osc_ready_i,
    input wire [NPER-1:0] periph_wr_req_i,
    output reg fast_osc_run_o,
    output reg cpu_clk_en_o,
    output reg [NPER-1:0] periph_clk_en_o,
    output reg [NPER-1:0] periph_wr_o,
    output reg [NPER-1:0] periph_resetn_o,
    output reg aux_clk_en_o,
    output reg aux_wr_o,
    output reg aux_resetn_o,
    output reg rtc_sub_clk_en_o
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [7:0] apply_wr;
    input [7:0] old;
    input [7:0] data;
    input bitop;
    input [2:0] sel;
    input [7:0] wmask;
    reg [7:0] m;
    begin
        m = bitop ? (8'h01 << sel) : 8'hFF;
        m = m & wmask;
        apply_wr = (old & ~m) | (data & m);
    end
endfunction

function [4:0] div_term;
    input [2:0] mdiv;
    reg [2:0] d;
    begin
        d = (mdiv > `FOPG_MDIV_MAX) ? `FOPG_MDIV_MAX : mdiv;
        div_term = (5'h01 << d) - 5'h01;
    end
endfunction

// ----------------------------------------
// states
// ----------------------------------------
localparam [3:0] ST_NORM = 4'b0001;
localparam [3:0] ST_TO_FAST = 4'b0010;
localparam [3:0] ST_FAST = 4'b0100;
localparam [3:0] ST_TO_NORM = 4'b1000;

reg [7:0] pce_r;
reg [1:0] foc_r;
reg [5:0] scd_r;
reg [3:0] st_r;
reg [3:0] st_nxt;
reg [4:0] div_cnt_r;
reg sub_half_r;
reg rdy_s1_r;
reg rdy_s2_r;
reg rdy_s3_r;
reg rdy_r;

wire fast_en = foc_r[0];
wire fast_sel = foc_r[1];
wire css = scd_r[5];
wire mcm = scd_r[4];
wire sdiv = scd_r[3];
wire [2:0] mdiv = scd_r[2:0];
wire wr_pce = sfr_wr_i && (sfr_addr_i == `FOPG_ADDR_PCE);
wire wr_foc = sfr_wr_i && (sfr_addr_i == `FOPG_ADDR_FOC);
wire wr_scd = sfr_wr_i && (sfr_addr_i == `FOPG_ADDR_SCD);

// ----------------------------------------
// register writes
// ----------------------------------------
wire [7:0] foc_view = {4'h0, 1'b0, foc_r[1], 1'b0, foc_r[0]};
wire [7:0] scd_view = {1'b0, scd_r[5], 1'b0, scd_r[4:0]};
wire [7:0] foc_new = apply_wr(foc_view, sfr_wdata_i, sfr_bit_i, sfr_bit_sel_i, `FOPG_WMASK_FOC); // [RULE2] [RULE18]
wire [7:0] scd_new = apply_wr(scd_view, sfr_wdata_i, sfr_bit_i, sfr_bit_sel_i, `FOPG_WMASK_SCD);
wire [7:0] pce_new = apply_wr(pce_r, sfr_wdata_i, sfr_bit_i, sfr_bit_sel_i, 8'hFF); // [RULE11]

always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        pce_r <= `FOPG_RST_PCE; // [RULE10]
        foc_r <= 2'h0; // [RULE1]
        scd_r <= 6'h09; // [RULE17] [RULE9]
    end else begin
        if (wr_pce) begin
            pce_r <= pce_new;
        end
        if (wr_foc) begin
            foc_r <= {foc_new[`FOPG_FOC_SEL], foc_new[`FOPG_FOC_EN]}; // [RULE5] [RULE3]
        end
        if (wr_scd) begin
            scd_r <= {scd_new[`FOPG_SCD_CSS], scd_new[`FOPG_SCD_MCM:0]};
        end
    end
end

// ----------------------------------------
// register reads
// ----------------------------------------
wire sup_flag = (st_r == ST_FAST);
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
        case (sfr_addr_i)
            `FOPG_ADDR_PCE: sfr_rdata_o <= pce_r;
            `FOPG_ADDR_FOC: sfr_rdata_o <= foc_view | ({7'h00, sup_flag} << `FOPG_FOC_SUP); // [RULE4] [RULE18]
            `FOPG_ADDR_SCD: sfr_rdata_o <= {css, css, mcm, scd_r[4:0]};
            default: sfr_rdata_o <= 8'h00;
        endcase
    end
end

// ----------------------------------------
// oscillator ready synchroniser
// ----------------------------------------
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rdy_s1_r <= 1'b0;
        rdy_s2_r <= 1'b0;
        rdy_s3_r <= 1'b0;
        rdy_r <= 1'b0;
    end else begin
        rdy_s1_r <= fast_osc_ready_i;
        rdy_s2_r <= rdy_s1_r;
        rdy_s3_r <= rdy_s2_r;
        if (rdy_s2_r == rdy_s3_r) begin
            rdy_r <= rdy_s3_r;
        end
    end
end

// ----------------------------------------
// cpu clock divider
// ----------------------------------------
wire main_tick = mcm ? mx_tick_i : ih_tick_i;
wire main_div_tick = main_tick && (div_cnt_r >= div_term(mdiv)); // [RULE8]
wire sub_div_tick = sub_tick_i && (!sdiv || sub_half_r);
wire norm_tick = css ? sub_div_tick : main_div_tick;
wire fast_tick = fast_osc_tick_i && fast_en && rdy_r;

always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        div_cnt_r <= 5'h00;
        sub_half_r <= 1'b0;
    end else begin
        if (main_tick) begin
            div_cnt_r <= main_div_tick ? 5'h00 : div_cnt_r + 5'h01;
        end
        if (sub_tick_i) begin
            sub_half_r <= ~sub_half_r;
        end
    end
end

// ----------------------------------------
// glitch-free clock switch
// ----------------------------------------
wire want_fast = fast_sel && fast_en && rdy_r;
always @* begin
    st_nxt = st_r;
    case (st_r)
        ST_NORM: begin
            if (want_fast && norm_tick) begin
                st_nxt = ST_TO_FAST; // [RULE19]
            end
        end
        ST_TO_FAST: begin
            if (!want_fast) begin
                st_nxt = ST_NORM;
            end else if (fast_tick) begin
                st_nxt = ST_FAST;
            end
        end
        ST_FAST: begin
            if (!fast_en || !rdy_r) begin
                st_nxt = ST_TO_NORM;
            end else if (!fast_sel && fast_tick) begin
                st_nxt = ST_TO_NORM; // [RULE19]
            end
        end
        ST_TO_NORM: begin
            if (norm_tick) begin
                st_nxt = ST_NORM;
            end
        end
        default: st_nxt = ST_NORM;
    endcase
end

wire cpu_tick = (st_r == ST_NORM && norm_tick) || (st_r == ST_FAST && fast_tick); // [RULE5]

always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        st_r <= ST_NORM;
        cpu_clk_en_o <= 1'b0;
        fast_osc_run_o <= 1'b0;
    end else begin
        st_r <= st_nxt;
        cpu_clk_en_o <= cpu_tick;
        fast_osc_run_o <= fast_en; // [RULE3]
    end
end

// ----------------------------------------
// peripheral gates
// ----------------------------------------
always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        periph_clk_en_o <= {NPER{1'b0}};
        periph_wr_o <= {NPER{1'b0}};
        periph_resetn_o <= {NPER{1'b0}};
        aux_clk_en_o <= 1'b0;
        aux_wr_o <= 1'b0;
        aux_resetn_o <= 1'b0;
        rtc_sub_clk_en_o <= 1'b0;
    end else begin
        periph_clk_en_o <= pce_r[NPER-1:0] & {NPER{cpu_tick}}; // [RULE12] [RULE13] [RULE14]
        periph_wr_o <= pce_r[NPER-1:0] & periph_wr_req_i; // [RULE13] [RULE14]
        periph_resetn_o <= pce_r[NPER-1:0]; // [RULE13]
        aux_clk_en_o <= pce_r[`FOPG_PCE_ADC] && cpu_tick; // [RULE15]
        aux_wr_o <= pce_r[`FOPG_PCE_ADC] && periph_wr_req_i[`FOPG_PCE_ADC]; // [RULE15]
        aux_resetn_o <= pce_r[`FOPG_PCE_ADC]; // [RULE15]
        rtc_sub_clk_en_o <= sub_tick_i; // [RULE16]
    end
end

endmodule // fopg_clock_ctrl
`default_nettype wire

// ===== verilog/fopg_defines.vh
// constants for the fast oscillator select and peripheral gate block
// Function
// [RULE1] fast oscillator control register resets to zero, oscillator off and unselected.
// [RULE2] fast oscillator control register takes single-bit and whole-byte writes.
// [RULE3] bit 0 stops the fast oscillator when 0, runs it when 1.
// [RULE4] bit 3 is read-only, high while the fast oscillator clock is supplied.
// [RULE5] bit 2 picks divider clock when 0, fast oscillator clock when 1.
// [RULE6] software waits 100 us after enabling the oscillator before selecting it.
// [RULE7] software keeps the internal oscillator running while the fast oscillator is enabled.
// [RULE8] cpu clock is main clock divided 1 to 32, or subclock divided 1 or 2.
// [RULE9] default cpu clock is internal oscillator divided by two.
// [RULE10] peripheral enable register resets to zero, all peripherals stopped and reset.
// [RULE11] peripheral enable register takes single-bit and whole-byte writes.
// [RULE12] enable bits 7..0: rtc, dac, adc, two-wire, serial 1, serial 0, timer 1, timer 0.
// [RULE13] a cleared enable stops the clock, blocks writes and holds reset.
// [RULE14] a set enable supplies the clock and allows reads and writes.
// [RULE15] adc enable also gates op-amp and voltage reference.
// [RULE16] rtc enable gates only the access clock; subclock to the counter keeps running.
// [RULE17] divider register resets to internal oscillator divided by two.
// [RULE18] unused bits 7..4 and 1 of the fast oscillator control read zero, ignore writes.
// [RULE19] switching to and from the fast clock is glitch-free; status follows completion.
`ifndef FOPG_DEFINES_VH
`define FOPG_DEFINES_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define FOPG_ADDR_PCE 20'hF00F0
`define FOPG_ADDR_FOC 20'hF00F6
`define FOPG_ADDR_SCD 20'hFFFA4
// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define FOPG_RST_PCE 8'h00
`define FOPG_RST_FOC 8'h00
`define FOPG_RST_SCD 8'h09
`define FOPG_WMASK_FOC 8'h05
`define FOPG_WMASK_SCD 8'h5F
// ----------------------------------------
// field positions
// ----------------------------------------
`define FOPG_FOC_EN 0
`define FOPG_FOC_SEL 2
`define FOPG_FOC_SUP 3
`define FOPG_SCD_CLS 7
`define FOPG_SCD_CSS 6
`define FOPG_SCD_MCS 5
`define FOPG_SCD_MCM 4
`define FOPG_SCD_SDIV 3
`define FOPG_SCD_MDIV_HI 2
`define FOPG_SCD_MDIV_LO 0
`define FOPG_PCE_ADC 5
`define FOPG_PCE_RTC 7
`define FOPG_MDIV_MAX 3'h5
`endif
